// File: sal_params.svh
// Purpose: shared constants: opcodes, word fields, float codes
// Assumes: included by the package and both ends; definitions only
// Notes:   field positions follow the two-dword instruction layout
//
// Operation
// RL1 - float unequal compare kills, writes 1.0/0.0
// RL2 - integer unequal compare kills, writes 1.0/0.0
// RL3 - kill compares act only in pixel programs
// RL4 - issuer places kill last in clause
// RL5 - scale double by power of two
// RL6 - infinity or NaN operand returned unchanged
// RL7 - zero or denormal operand gives signed zero
// RL8 - add exponent; overflow infinity, underflow zero
// RL9 - scaling occupies slot pair 0-1 or 2-3
// RL10 - input modifiers only at slot 0/2
// RL11 - output modifiers only at slot 0/2
// RL12 - per-byte rounded average, packed result
// RL13 - load flags from source, store old flags
// RL14 - flag load-store only in w channel
// RL15 - clamped log: 1.0 gives 0, -inf clamped
// RL16 - IEEE log: 1.0 gives 0, else approximate
// RL17 - left shift, amount above 31 gives 0
// RL18 - right shift by five low bits
// RL19 - float max returns first when greater-equal
// RL20 - double max strict, signed zeros give +0
// RL21 - source word at +0, opcode word +4
// RL22 - opcode 64 is unsigned greater kill
// RL23 - unsigned greater compare kills, writes 1.0/0.0
`ifndef SAL_PARAMS_SVH
`define SAL_PARAMS_SVH

// two-source opcodes
`define SAL_OP_FLOAT_MAX        11'h003
`define SAL_OP_RIGHT_SHIFT      11'h016
`define SAL_OP_LEFT_SHIFT       11'h017
`define SAL_OP_FLOAT_NE_KILL    11'h02F
`define SAL_OP_UGT_KILL         11'h040
`define SAL_OP_INT_NE_KILL      11'h049
`define SAL_OP_CLAMPED_LOG      11'h082
`define SAL_OP_IEEE_LOG         11'h083
`define SAL_OP_DOUBLE_MAX       11'h0BE
`define SAL_OP_DOUBLE_SCALE     11'h0C5
`define SAL_OP_FLAGS_LOAD_STORE 11'h0DB
// three-source opcode
`define SAL_OP3_LANE_AVG        5'h0B

// source_select_word (+0) fields
`define SAL_W0_S0N      12
`define SAL_W0_S1N      25
`define SAL_W0_LAST     31
// two_source_opcode_word (+4) fields
`define SAL_W1_WM       4
`define SAL_W1_OUTPUT_MODIFIER_FIELD_LSB 5
`define SAL_W1_OUTPUT_MODIFIER_FIELD_MSB 6
`define SAL_W1_OP2_LSB  7
`define SAL_W1_OP2_MSB  17
`define SAL_W1_OP3_LSB  13
`define SAL_W1_OP3_GRD  15
`define SAL_W1_GPR_LSB  21
`define SAL_W1_GPR_MSB  27
`define SAL_W1_CHAN_LSB 29
`define SAL_W1_CHAN_MSB 30

// slots, channels and output modifier codes
`define SAL_SLOT_PAIR_LO 3'h0
`define SAL_SLOT_PAIR_HI 3'h2
`define SAL_CHAN_W       2'h3
`define SAL_OUTPUT_MODIFIER_FIELD_MUL2    2'h1
`define SAL_OUTPUT_MODIFIER_FIELD_MUL4    2'h2
`define SAL_OUTPUT_MODIFIER_FIELD_DIV2    2'h3

// exception flag bits
`define SAL_FLAG_W       4
`define SAL_FLG_INVALID  0
`define SAL_FLG_DIVZERO  1
`define SAL_FLG_OVERFLOW 2
`define SAL_FLG_UNDERFL  3

// float codes
`define SAL_F_ONE      32'h3F800000
`define SAL_F_ZERO     32'h00000000
`define SAL_F_POS_INF  32'h7F800000
`define SAL_F_NEG_INF  32'hFF800000
`define SAL_F_NEG_MAX  32'hFF7FFFFF
`define SAL_F_QNAN     32'h7FC00000
`define SAL_F_EXP_ONES 8'hFF
`define SAL_F_BIAS     9'h07F
`define SAL_F_EXP_ADJ  8'h68
`define SAL_D_EXP_ONES 11'h7FF
`define SAL_D_EXP_MSB  62
`define SAL_D_EXP_LSB  52
`define SAL_D_POS_ZERO 64'h0000000000000000

`endif

// File: sal_pkg.sv
// Purpose: types shared by the two ends of the shader ALU slice
// Assumes: sal_params.svh
// Notes:   each end keeps all of its state in one of these structs
`include "sal_params.svh"

package sal_pkg;

	typedef struct packed {
		logic					res_valid;
		logic					res_we;
		logic					res_wide;
		logic [63:0]			res_data;
		logic [6:0]				res_gpr;
		logic [1:0]				res_chan;
		logic					res_kill;
		logic [`SAL_FLAG_W-1:0] flags;
	} sal_dev_state_type;

	typedef enum logic [2:0] {
		SAL_IDLE  = 3'h1,
		SAL_ISSUE = 3'h2,
		SAL_WAIT  = 3'h4
	} sal_host_fsm_type;

	typedef struct packed {
		sal_host_fsm_type		fsm;
		logic					cmd_ready;
		logic					cmd_refused;
		logic					iss_valid;
		logic [31:0]			iss_word0;
		logic [31:0]			iss_word1;
		logic [63:0]			iss_src0;
		logic [63:0]			iss_src1;
		logic [31:0]			iss_src2;
		logic [2:0]				iss_slot;
		logic					iss_pixel;
		logic					rsp_valid;
		logic					rsp_we;
		logic [63:0]			rsp_data;
		logic					rsp_kill;
		logic [`SAL_FLAG_W-1:0] rsp_flags;
	} sal_host_state_type;

endpackage

// File: sal_link_if.sv
// Purpose: issue and result link between the sequencer and the ALU slice
// Assumes: sal_params.svh
// Notes:   one issue per cycle at most; the result follows one cycle later
`include "sal_params.svh"

interface sal_link_if;
	// issue group
	logic					iss_valid;
	logic [31:0]			iss_word0;
	logic [31:0]			iss_word1;
	logic [63:0]			iss_src0;
	logic [63:0]			iss_src1;
	logic [31:0]			iss_src2;
	logic [2:0]				iss_slot;
	logic					iss_pixel;
	// result group
	logic					res_valid;
	logic					res_we;
	logic					res_wide;
	logic [63:0]			res_data;
	logic [6:0]				res_gpr;
	logic [1:0]				res_chan;
	logic					res_kill;
	logic [`SAL_FLAG_W-1:0] res_flags;

	modport dev (
		input  iss_valid, iss_word0, iss_word1, iss_src0, iss_src1, iss_src2, iss_slot, iss_pixel,
		output res_valid, res_we, res_wide, res_data, res_gpr, res_chan, res_kill, res_flags
	);
	modport host (
		output iss_valid, iss_word0, iss_word1, iss_src0, iss_src1, iss_src2, iss_slot, iss_pixel,
		input  res_valid, res_we, res_wide, res_data, res_gpr, res_chan, res_kill, res_flags
	);
endinterface

// File: sal_alu_dev.sv
// Purpose: ALU slice executing kill compares, double scaling, byte average,
//          flag load-store, base-2 logs, shifts and maxima
// Assumes: one instruction per cycle on the link; result one cycle later
// Notes:   NaN inputs make float equal and greater-equal tests false, so the unequal compare kills
`include "sal_params.svh"

module sal_alu_dev (
	// clock and reset
	input  wire logic					ref_clk,
	input  wire logic					rst_n,
	// sequencer link
	sal_link_if.dev						link,
	// user side
	output logic [`SAL_FLAG_W-1:0]		exc_flags,
	output logic						kill_event
);
	import sal_pkg::*;

	sal_dev_state_type st_ff;
	sal_dev_state_type nxt_st;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic f32_nan(input logic [31:0] x);
		return (x[30:23] == `SAL_F_EXP_ONES) && (x[22:0] != 23'h0);
	endfunction

	function automatic logic [31:0] f32_key(input logic [31:0] x);
		return x[31] ? ~x : {1'b1, x[30:0]};
	endfunction

	// +0 and -0 compare equal
	function automatic logic f32_eq(input logic [31:0] a, input logic [31:0] b);
		return !f32_nan(a) && !f32_nan(b) && ((a == b) || ((a[30:0] == 31'h0) && (b[30:0] == 31'h0)));
	endfunction

	function automatic logic f32_ge(input logic [31:0] a, input logic [31:0] b);
		return f32_eq(a, b) || (!f32_nan(a) && !f32_nan(b) && (f32_key(a) > f32_key(b)));
	endfunction

	function automatic logic f64_nan(input logic [63:0] x);
		return (x[62:52] == `SAL_D_EXP_ONES) && (x[51:0] != 52'h0);
	endfunction

	function automatic logic [63:0] f64_key(input logic [63:0] x);
		return x[63] ? ~x : {1'b1, x[62:0]};
	endfunction

	// result data in low 64 bits, raised flags above
	function automatic logic [`SAL_FLAG_W+63:0] pow2_scale(input logic [63:0] d, input logic [31:0] e,
		input logic [1:0] om);
		logic [10:0]            ex;
		logic signed [33:0]     sum;
		logic signed [33:0]     adj;
		logic [`SAL_FLAG_W-1:0] fl;
		logic [63:0]            r;
		ex = d[`SAL_D_EXP_MSB:`SAL_D_EXP_LSB];
		fl = '0;
		case (om)
			`SAL_OUTPUT_MODIFIER_FIELD_MUL2: adj = 34'sh1;
			`SAL_OUTPUT_MODIFIER_FIELD_MUL4: adj = 34'sh2;
			`SAL_OUTPUT_MODIFIER_FIELD_DIV2: adj = -34'sh1;
			default:        adj = 34'sh0;
		endcase
		sum = $signed({23'h0, ex}) + $signed({{2{e[31]}}, e}) + adj;
		if (ex == `SAL_D_EXP_ONES) begin
			r = d; // [RL6]
		end else if (ex == 11'h0) begin
			r = {d[63], 63'h0}; // [RL7]
		end else if (sum >= $signed({23'h0, `SAL_D_EXP_ONES})) begin
			r = {d[63], `SAL_D_EXP_ONES, 52'h0}; // [RL8]
			fl[`SAL_FLG_OVERFLOW] = 1'b1;
		end else if (sum <= 34'sh0) begin
			r = {d[63], 63'h0}; // [RL8]
			fl[`SAL_FLG_UNDERFL] = 1'b1;
		end else begin
			r = {d[63], sum[10:0], d[51:0]}; // [RL5] [RL8]
		end
		return {fl, r};
	endfunction

	// piecewise-linear log2: exponent plus raw fraction, renormalised to float
	function automatic logic [`SAL_FLAG_W+31:0] log2_approx(input logic [31:0] x, input logic clamp);
		logic [`SAL_FLAG_W-1:0] fl;
		logic [31:0]            r;
		logic [8:0]             ue;
		logic [31:0]            fx;
		logic [31:0]            mag;
		logic [4:0]             p;
		logic [31:0]            nrm;
		fl = '0;
		ue = {1'b0, x[30:23]} - `SAL_F_BIAS;
		fx = {ue, x[22:0]};
		mag = fx[31] ? (~fx + 32'h1) : fx;
		p = 5'h0;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				p = 5'(i);
			end
		end
		nrm = mag << (5'h1F - p);
		if (x == `SAL_F_ONE) begin
			r = `SAL_F_ZERO; // [RL15] [RL16]
		end else if (x[30:23] == 8'h0) begin
			r = `SAL_F_NEG_INF;
			fl[`SAL_FLG_DIVZERO] = 1'b1;
		end else if (f32_nan(x)) begin
			r = x;
		end else if (x[31]) begin
			r = `SAL_F_QNAN;
			fl[`SAL_FLG_INVALID] = 1'b1;
		end else if (x[30:23] == `SAL_F_EXP_ONES) begin
			r = `SAL_F_POS_INF;
		end else if (mag == 32'h0) begin
			r = `SAL_F_ZERO;
		end else begin
			r = {fx[31], {3'h0, p} + `SAL_F_EXP_ADJ, nrm[30:8]}; // [RL16]
		end
		if (clamp && (r == `SAL_F_NEG_INF)) begin
			r = `SAL_F_NEG_MAX; // [RL15]
		end
		return {fl, r};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [31:0]                w0;
		logic [31:0]                w1;
		logic [31:0]                a;
		logic [31:0]                b;
		logic [31:0]                af;
		logic [31:0]                bf;
		logic [63:0]                dbl;
		logic [10:0]                opc;
		logic                       is_op3;
		logic                       pair_start;
		logic                       we;
		logic                       wide;
		logic                       kill;
		logic                       load_flags;
		logic [63:0]                data;
		logic [8:0]                 lane;
		logic [`SAL_FLAG_W-1:0]     raised;
		logic [`SAL_FLAG_W+63:0]    sc;
		logic [`SAL_FLAG_W+31:0]    lg;
		nxt_st = st_ff;
		nxt_st.res_valid = 1'b0;
		nxt_st.res_kill = 1'b0;
		// source word at +0, opcode word at +4
		w0 = link.iss_word0; // [RL21]
		w1 = link.iss_word1; // [RL21]
		a = link.iss_src0[31:0];
		b = link.iss_src1[31:0];
		af = {a[31] ^ w0[`SAL_W0_S0N], a[30:0]};
		bf = {b[31] ^ w0[`SAL_W0_S1N], b[30:0]};
		opc = w1[`SAL_W1_OP2_MSB:`SAL_W1_OP2_LSB];
		is_op3 = |w1[`SAL_W1_OP2_MSB:`SAL_W1_OP3_GRD];
		pair_start = (link.iss_slot == `SAL_SLOT_PAIR_LO) || (link.iss_slot == `SAL_SLOT_PAIR_HI);
		we = w1[`SAL_W1_WM];
		wide = 1'b0;
		kill = 1'b0;
		load_flags = 1'b0;
		data = '0;
		lane = '0;
		raised = '0;
		dbl = '0;
		sc = '0;
		lg = '0;
		if (link.iss_valid) begin
			if (is_op3) begin
				if (w1[`SAL_W1_OP2_MSB:`SAL_W1_OP3_LSB] == `SAL_OP3_LANE_AVG) begin
					for (int i = 0; i < 4; i++) begin
						lane = {1'b0, a[i*8 +: 8]} + {1'b0, b[i*8 +: 8]} + {8'h0, link.iss_src2[i*8]};
						data[i*8 +: 8] = lane[8:1]; // [RL12]
					end
				end else begin
					we = 1'b0;
				end
			end else begin
				case (opc)
					`SAL_OP_FLOAT_NE_KILL: begin
						kill = !f32_eq(af, bf); // [RL1]
					end
					`SAL_OP_INT_NE_KILL: begin
						kill = (a != b); // [RL2]
					end
					`SAL_OP_UGT_KILL: begin
						kill = (a > b); // [RL22] [RL23]
					end
					`SAL_OP_DOUBLE_SCALE: begin
						// modifiers ride on the pair-start slot only; the exponent takes none
						dbl = {link.iss_src1[63] ^ w0[`SAL_W0_S1N], link.iss_src1[62:0]}; // [RL10]
						sc = pow2_scale(dbl, a, w1[`SAL_W1_OUTPUT_MODIFIER_FIELD_MSB:`SAL_W1_OUTPUT_MODIFIER_FIELD_LSB]); // [RL5] [RL11]
						data = sc[63:0];
						raised = sc[`SAL_FLAG_W+63:64];
						wide = 1'b1;
						if (!pair_start) begin
							we = 1'b0; // [RL9]
							raised = '0;
						end
					end
					`SAL_OP_FLAGS_LOAD_STORE: begin
						if (link.iss_slot[1:0] == `SAL_CHAN_W) begin
							data = {{(64 - `SAL_FLAG_W){1'b0}}, st_ff.flags}; // [RL13]
							load_flags = 1'b1; // [RL14]
						end else begin
							we = 1'b0; // [RL14]
						end
					end
					`SAL_OP_CLAMPED_LOG, `SAL_OP_IEEE_LOG: begin
						lg = log2_approx(af, opc == `SAL_OP_CLAMPED_LOG); // [RL15] [RL16]
						data = {32'h0, lg[31:0]};
						raised = lg[`SAL_FLAG_W+31:32];
					end
					`SAL_OP_LEFT_SHIFT: begin
						data = {32'h0, (b > 32'h1F) ? 32'h0 : (a << b[4:0])}; // [RL17]
					end
					`SAL_OP_RIGHT_SHIFT: begin
						data = {32'h0, a >> b[4:0]}; // [RL18]
					end
					`SAL_OP_FLOAT_MAX: begin
						data = {32'h0, f32_ge(af, bf) ? af : bf}; // [RL19]
					end
					`SAL_OP_DOUBLE_MAX: begin
						wide = 1'b1;
						if ((link.iss_src0[62:0] == 63'h0) && (link.iss_src1[62:0] == 63'h0)) begin
							data = `SAL_D_POS_ZERO; // [RL20]
						end else if (!f64_nan(link.iss_src0) && !f64_nan(link.iss_src1)
							&& (f64_key(link.iss_src0) > f64_key(link.iss_src1))) begin
							data = link.iss_src0; // [RL20]
						end else begin
							data = link.iss_src1; // [RL20]
						end
					end
					default: begin
						we = 1'b0;
					end
				endcase
				if ((opc == `SAL_OP_FLOAT_NE_KILL) || (opc == `SAL_OP_INT_NE_KILL) || (opc == `SAL_OP_UGT_KILL)) begin
					data = {32'h0, kill ? `SAL_F_ONE : `SAL_F_ZERO};
					if (!link.iss_pixel) begin
						we = 1'b0; // [RL3]
						kill = 1'b0; // [RL3]
					end
				end
			end
			nxt_st.res_valid = 1'b1;
			nxt_st.res_we = we;
			nxt_st.res_wide = wide;
			nxt_st.res_data = data;
			nxt_st.res_gpr = w1[`SAL_W1_GPR_MSB:`SAL_W1_GPR_LSB];
			nxt_st.res_chan = w1[`SAL_W1_CHAN_MSB:`SAL_W1_CHAN_LSB];
			nxt_st.res_kill = kill;
			// flags are sticky until a load replaces them
			nxt_st.flags = load_flags ? a[`SAL_FLAG_W-1:0] : (st_ff.flags | raised); // [RL13]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link.res_valid = st_ff.res_valid;
	assign link.res_we    = st_ff.res_we;
	assign link.res_wide  = st_ff.res_wide;
	assign link.res_data  = st_ff.res_data;
	assign link.res_gpr   = st_ff.res_gpr;
	assign link.res_chan  = st_ff.res_chan;
	assign link.res_kill  = st_ff.res_kill;
	assign link.res_flags = st_ff.flags;
	assign exc_flags      = st_ff.flags;
	assign kill_event     = st_ff.res_kill;

endmodule

// File: sal_seq_host.sv
// Purpose: sequencer end: encodes commands into instruction words, issues them, returns results
// Assumes: the ALU answers one cycle after each issue
// Notes:   misplaced commands are refused here so the ALU never sees them
`include "sal_params.svh"

module sal_seq_host (
	// clock and reset
	input  wire logic					ref_clk,
	input  wire logic					rst_n,
	// command
	input  wire logic					cmd_valid,
	input  wire logic					cmd_op3,
	input  wire logic [10:0]			cmd_opcode,
	input  wire logic [63:0]			cmd_src0,
	input  wire logic [63:0]			cmd_src1,
	input  wire logic [31:0]			cmd_src2,
	input  wire logic [2:0]				cmd_slot,
	input  wire logic [1:0]				cmd_chan,
	input  wire logic					cmd_pixel,
	input  wire logic [6:0]				cmd_gpr,
	input  wire logic [1:0]				cmd_output_modifier_field,
	input  wire logic					cmd_neg0,
	input  wire logic					cmd_neg1,
	input  wire logic					cmd_we,
	input  wire logic					cmd_last,
	output logic						cmd_ready,
	output logic						cmd_refused,
	// response
	output logic						rsp_valid,
	output logic						rsp_we,
	output logic [63:0]					rsp_data,
	output logic						rsp_kill,
	output logic [`SAL_FLAG_W-1:0]		rsp_flags,
	// ALU link
	sal_link_if.host					link
);
	import sal_pkg::*;

	sal_host_state_type st_ff;
	sal_host_state_type nxt_st;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic is_kill;
		logic bad;
		nxt_st = st_ff;
		nxt_st.cmd_refused = 1'b0;
		nxt_st.rsp_valid = 1'b0;
		nxt_st.iss_valid = 1'b0;
		is_kill = !cmd_op3 && ((cmd_opcode == `SAL_OP_FLOAT_NE_KILL) || (cmd_opcode == `SAL_OP_INT_NE_KILL)
			|| (cmd_opcode == `SAL_OP_UGT_KILL));
		// later instructions in a clause would not see the new pixel validity
		bad = (is_kill && !cmd_last); // [RL4]
		if (!cmd_op3 && (cmd_opcode == `SAL_OP_DOUBLE_SCALE)
			&& (cmd_slot != `SAL_SLOT_PAIR_LO) && (cmd_slot != `SAL_SLOT_PAIR_HI)) begin
			bad = 1'b1; // [RL9]
		end
		if (!cmd_op3 && (cmd_opcode == `SAL_OP_FLAGS_LOAD_STORE) && (cmd_slot[1:0] != `SAL_CHAN_W)) begin
			bad = 1'b1; // [RL14]
		end
		case (st_ff.fsm)
			SAL_IDLE: begin
				if (cmd_valid && st_ff.cmd_ready) begin
					if (bad) begin
						nxt_st.cmd_refused = 1'b1;
					end else begin
						nxt_st.iss_word0 = '0;
						nxt_st.iss_word0[`SAL_W0_S0N] = cmd_neg0;
						nxt_st.iss_word0[`SAL_W0_S1N] = cmd_neg1;
						nxt_st.iss_word0[`SAL_W0_LAST] = cmd_last;
						nxt_st.iss_word1 = '0;
						if (cmd_op3) begin
							nxt_st.iss_word1[`SAL_W1_OP2_MSB:`SAL_W1_OP3_LSB] = cmd_opcode[4:0];
						end else begin
							nxt_st.iss_word1[`SAL_W1_OP2_MSB:`SAL_W1_OP2_LSB] = cmd_opcode;
							nxt_st.iss_word1[`SAL_W1_OUTPUT_MODIFIER_FIELD_MSB:`SAL_W1_OUTPUT_MODIFIER_FIELD_LSB] = cmd_output_modifier_field;
						end
						nxt_st.iss_word1[`SAL_W1_WM] = cmd_we;
						nxt_st.iss_word1[`SAL_W1_GPR_MSB:`SAL_W1_GPR_LSB] = cmd_gpr;
						nxt_st.iss_word1[`SAL_W1_CHAN_MSB:`SAL_W1_CHAN_LSB] = cmd_chan; // [RL21]
						nxt_st.iss_src0 = cmd_src0;
						nxt_st.iss_src1 = cmd_src1;
						nxt_st.iss_src2 = cmd_src2;
						nxt_st.iss_slot = cmd_slot;
						nxt_st.iss_pixel = cmd_pixel;
						nxt_st.iss_valid = 1'b1;
						nxt_st.cmd_ready = 1'b0;
						nxt_st.fsm = SAL_ISSUE;
					end
				end
			end
			SAL_ISSUE: begin
				nxt_st.fsm = SAL_WAIT;
			end
			SAL_WAIT: begin
				if (link.res_valid) begin
					nxt_st.rsp_valid = 1'b1;
					nxt_st.rsp_we = link.res_we;
					nxt_st.rsp_data = link.res_data;
					nxt_st.rsp_kill = link.res_kill;
					nxt_st.rsp_flags = link.res_flags;
					nxt_st.cmd_ready = 1'b1;
					nxt_st.fsm = SAL_IDLE;
				end
			end
			default: begin
				nxt_st.fsm = SAL_IDLE;
				nxt_st.cmd_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{fsm: SAL_IDLE, cmd_ready: 1'b1, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign cmd_ready      = st_ff.cmd_ready;
	assign cmd_refused    = st_ff.cmd_refused;
	assign rsp_valid      = st_ff.rsp_valid;
	assign rsp_we         = st_ff.rsp_we;
	assign rsp_data       = st_ff.rsp_data;
	assign rsp_kill       = st_ff.rsp_kill;
	assign rsp_flags      = st_ff.rsp_flags;
	assign link.iss_valid = st_ff.iss_valid;
	assign link.iss_word0 = st_ff.iss_word0;
	assign link.iss_word1 = st_ff.iss_word1;
	assign link.iss_src0  = st_ff.iss_src0;
	assign link.iss_src1  = st_ff.iss_src1;
	assign link.iss_src2  = st_ff.iss_src2;
	assign link.iss_slot  = st_ff.iss_slot;
	assign link.iss_pixel = st_ff.iss_pixel;

endmodule

// File: sal_link_monitor.sv
// Purpose: checker on the link between the sequencer end and the ALU end
// Assumes: instantiated by the bench top beside the link interface
// Notes:   float unequal and double scale checks cover unmodified operands only
`include "sal_params.svh"

module sal_link_monitor (
	// clock and reset
	input wire logic			ref_clk,
	input wire logic			rst_n,
	// issue group
	input wire logic			iss_valid,
	input wire logic [31:0]			iss_word0,
	input wire logic [31:0]			iss_word1,
	input wire logic [63:0]			iss_src0,
	input wire logic [63:0]			iss_src1,
	input wire logic [31:0]			iss_src2,
	input wire logic [2:0]			iss_slot,
	input wire logic			iss_pixel,
	// result group
	input wire logic			res_valid,
	input wire logic			res_we,
	input wire logic [63:0]			res_data,
	input wire logic			res_kill,
	input wire logic [`SAL_FLAG_W-1:0]	res_flags
);
	import sal_pkg::*;
	function automatic logic [7:0] lane(input logic [7:0] x, input logic [7:0] y, input logic r);
		return 8'((9'(x) + 9'(y) + 9'(r)) >> 1);
	endfunction
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic [10:0]	op = iss_word1[17:7];
	wire logic [31:0]	a = iss_src0[31:0];
	wire logic [31:0]	b = iss_src1[31:0];
	wire logic [3:0]	fl_new = a[3:0];
	wire logic		sgn = iss_src1[63];
	wire logic		plain = !iss_word0[`SAL_W0_S0N] && !iss_word0[`SAL_W0_S1N] && iss_word1[6:5] == 2'h0;
	// NaN compares are left out: bitwise equal NaNs still count as unequal
	wire logic		num = a[30:23] != 8'hFF && b[30:23] != 8'hFF;
	wire logic		fne = a != b && (a[30:0] | b[30:0]) != 31'h0;
	wire logic		ine = a != b;
	wire logic		ugt = a > b;
	wire logic [31:0]	shl = b > 32'h1F ? 32'h0 : a << b[4:0];
	wire logic [31:0]	shr = a >> b[4:0];
	wire logic [31:0]	avg = {lane(a[31:24], b[31:24], iss_src2[24]), lane(a[23:16], b[23:16], iss_src2[16]),
		lane(a[15:8], b[15:8], iss_src2[8]), lane(a[7:0], b[7:0], iss_src2[0])};
	////////////////////////////////////////////////////////////////////////////////
	sequence issued(logic [10:0] code);
		iss_valid && op == code;
	endsequence
	sequence killer(logic [10:0] code);
		iss_valid && iss_pixel && op == code;
	endsequence
	sequence scale_pair;
		issued(`SAL_OP_DOUBLE_SCALE) ##0 plain && iss_slot inside {3'h0, 3'h2};
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	answer_lat_a: assert property (iss_valid |=> res_valid)
		else $error("no result after issue");
	pixel_only_a: assert property (iss_valid && !iss_pixel |=> !res_kill)
		else $error("kill outside pixel program");
	float_ne_a: assert property (killer(`SAL_OP_FLOAT_NE_KILL) ##0 plain && num |=> res_kill == $past(fne))
		else $error("float unequal kill wrong");
	int_ne_a: assert property (killer(`SAL_OP_INT_NE_KILL) |=> res_kill == $past(ine)
		&& res_data[31:0] == (res_kill ? `SAL_F_ONE : `SAL_F_ZERO)) else $error("integer unequal kill wrong");
	unsigned_gt_a: assert property (killer(`SAL_OP_UGT_KILL) |=> res_kill == $past(ugt)
		&& res_data[31:0] == (res_kill ? `SAL_F_ONE : `SAL_F_ZERO)) else $error("unsigned greater kill wrong");
	left_shift_a: assert property (issued(`SAL_OP_LEFT_SHIFT) |=> res_data[31:0] == $past(shl))
		else $error("left shift wrong");
	right_shift_a: assert property (issued(`SAL_OP_RIGHT_SHIFT) |=> res_data[31:0] == $past(shr))
		else $error("right shift wrong");
	lane_avg_a: assert property (iss_valid && iss_word1[17:13] == `SAL_OP3_LANE_AVG
		|=> res_data[31:0] == $past(avg)) else $error("byte average wrong");
	flag_swap_a: assert property (issued(`SAL_OP_FLAGS_LOAD_STORE) ##0 iss_slot[1:0] == `SAL_CHAN_W
		|=> res_flags == $past(fl_new) && res_data[3:0] == $past(res_flags)) else $error("flag load store wrong");
	scale_inf_a: assert property (scale_pair ##0 iss_src1[62:52] == `SAL_D_EXP_ONES
		|=> res_data == $past(iss_src1)) else $error("scaled inf or NaN altered");
	scale_zero_a: assert property (scale_pair ##0 iss_src1[62:52] == 11'h000
		|=> res_data == {$past(sgn), 63'h0}) else $error("scaled zero wrong");
endmodule

// File: shader_alu_kill_ldexp_shift_ops_tb.sv
// Purpose: bench joining the sequencer end and the ALU end across the link
// Assumes: commands driven on the falling edge, one outstanding at a time
// Notes:   status code per command: 2 written, 3 written and killed, 4 refused, 0 dropped
`include "sal_params.svh"

module shader_alu_kill_ldexp_shift_ops_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sal_pkg::*;
	logic		ref_clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		cmd_valid = 1'b0, cmd_op3 = 1'b0, cmd_pixel = 1'b1, cmd_last = 1'b1, cmd_neg1 = 1'b0;
	logic [10:0]	cmd_opcode = 11'h000;
	logic [63:0]	cmd_src0 = 64'h0, cmd_src1 = 64'h0, rsp_data;
	logic [31:0]	cmd_src2 = 32'h0;
	logic [2:0]	cmd_slot = 3'h0;
	logic [1:0]	cmd_output_modifier_field = 2'h0;
	logic		cmd_ready, cmd_refused, rsp_valid, rsp_we, rsp_kill, kill_event, got_ref;
	logic [3:0]	rsp_flags, exc_flags;
	int		miscompares = 0, checked = 0, kills = 0;
	sal_link_if	link ();
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (kill_event === 1'b1) kills++;
	////////////////////////////////////////////////////////////////////////////////
	sal_seq_host u_sal_seq_host (.ref_clk, .rst_n, .cmd_valid, .cmd_op3, .cmd_opcode, .cmd_src0, .cmd_src1,
		.cmd_src2, .cmd_slot, .cmd_chan(cmd_slot[1:0]), .cmd_pixel, .cmd_gpr(7'h05), .cmd_output_modifier_field, .cmd_neg0(1'b0),
		.cmd_neg1, .cmd_we(1'b1), .cmd_last, .cmd_ready, .cmd_refused, .rsp_valid, .rsp_we, .rsp_data,
		.rsp_kill, .rsp_flags, .link(link));
	sal_alu_dev u_sal_alu_dev (.ref_clk, .rst_n, .link(link), .exc_flags, .kill_event);
	sal_link_monitor u_sal_link_monitor (.ref_clk, .rst_n, .iss_valid(link.iss_valid), .iss_word0(link.iss_word0),
		.iss_word1(link.iss_word1), .iss_src0(link.iss_src0), .iss_src1(link.iss_src1), .iss_src2(link.iss_src2),
		.iss_slot(link.iss_slot), .iss_pixel(link.iss_pixel), .res_valid(link.res_valid), .res_we(link.res_we),
		.res_data(link.res_data), .res_kill(link.res_kill), .res_flags(link.res_flags));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one command, wait for its answer, then compare status and (when written) data
	task automatic run(input logic [10:0] op, input logic [63:0] a, b, input logic [2:0] sl,
		st, input logic [63:0] exp);
		int i;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_opcode = op;
		cmd_src0 = a;
		cmd_src1 = b;
		cmd_slot = sl;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 8 && cmd_refused !== 1'b1 && rsp_valid !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 8) begin
			miscompares++;
			end_sim();
		end
		got_ref = cmd_refused;
		chk(got_ref ? 64'h4 : {62'h0, rsp_we, rsp_kill}, {61'h0, st});
		if (!got_ref && rsp_we)
			chk(op == 11'h0C5 || op == 11'h0BE ? rsp_data : {32'h0, rsp_data[31:0]}, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		run(11'h0DB, 64'h5, 64'h0, 3'h3, 3'h2, 64'h0);
		run(11'h0DB, 64'h0, 64'h0, 3'h3, 3'h2, 64'h5);
		chk({60'h0, exc_flags}, 64'h0);
		run(11'h0DB, 64'h1, 64'h0, 3'h0, 3'h4, 64'h0);
		run(11'h02F, 64'h3F800000, 64'h40000000, 3'h0, 3'h3, 64'h3F800000);
		run(11'h02F, 64'h80000000, 64'h0, 3'h0, 3'h2, 64'h0);
		run(11'h049, 64'h80000000, 64'h0, 3'h0, 3'h3, 64'h3F800000);
		run(11'h049, 64'h7, 64'h7, 3'h0, 3'h2, 64'h0);
		run(11'h040, 64'hFFFFFFFF, 64'h1, 3'h0, 3'h3, 64'h3F800000);
		run(11'h040, 64'h1, 64'hFFFFFFFF, 3'h0, 3'h2, 64'h0);
		cmd_last = 1'b0;
		run(11'h02F, 64'h1, 64'h2, 3'h0, 3'h4, 64'h0);
		cmd_last = 1'b1;
		cmd_pixel = 1'b0;
		run(11'h049, 64'h1, 64'h2, 3'h0, 3'h0, 64'h0);
		cmd_pixel = 1'b1;
		run(11'h0C5, 64'h3, 64'h3FF0000000000000, 3'h0, 3'h2, 64'h4020000000000000);
		run(11'h0C5, 64'h800, 64'h3FF0000000000000, 3'h2, 3'h2, 64'h7FF0000000000000);
		run(11'h0C5, 64'hFFFFFC01, 64'hBFF0000000000000, 3'h0, 3'h2, 64'h8000000000000000);
		run(11'h0C5, 64'h5, 64'hFFF8000000000001, 3'h0, 3'h2, 64'hFFF8000000000001);
		run(11'h0C5, 64'h5, 64'h800000000000ABCD, 3'h2, 3'h2, 64'h8000000000000000);
		run(11'h0C5, 64'h0, 64'h3FF0000000000000, 3'h1, 3'h4, 64'h0);
		cmd_output_modifier_field = 2'h1;
		run(11'h0C5, 64'h0, 64'h3FF0000000000000, 3'h0, 3'h2, 64'h4000000000000000);
		cmd_output_modifier_field = 2'h0;
		cmd_neg1 = 1'b1;
		run(11'h0C5, 64'h1, 64'h3FF0000000000000, 3'h2, 3'h2, 64'hC000000000000000);
		cmd_neg1 = 1'b0;
		cmd_op3 = 1'b1;
		cmd_src2 = 32'h01000100;
		run(11'h00B, 64'hFF010203, 64'hFF000101, 3'h0, 3'h2, 64'hFF000202);
		cmd_op3 = 1'b0;
		run(11'h082, 64'h3F800000, 64'h0, 3'h0, 3'h2, 64'h0);
		run(11'h082, 64'h0, 64'h0, 3'h0, 3'h2, 64'hFF7FFFFF);
		chk({60'h0, rsp_flags}, 64'hE);
		run(11'h083, 64'h3F800000, 64'h0, 3'h0, 3'h2, 64'h0);
		run(11'h083, 64'h40000000, 64'h0, 3'h0, 3'h2, 64'h3F800000);
		run(11'h017, 64'h80000001, 64'h1F, 3'h0, 3'h2, 64'h80000000);
		run(11'h017, 64'h1, 64'h20, 3'h0, 3'h2, 64'h0);
		run(11'h016, 64'h80000001, 64'h21, 3'h0, 3'h2, 64'h40000000);
		run(11'h003, 64'h80000000, 64'h0, 3'h0, 3'h2, 64'h80000000);
		run(11'h003, 64'h3F800000, 64'h40000000, 3'h0, 3'h2, 64'h40000000);
		run(11'h0BE, 64'h8000000000000000, 64'h0, 3'h0, 3'h2, 64'h0);
		run(11'h0BE, 64'h0, 64'h8000000000000000, 3'h0, 3'h2, 64'h0);
		run(11'h0BE, 64'h4000000000000000, 64'h3FF0000000000000, 3'h0, 3'h2, 64'h4000000000000000);
		chk(64'(kills), 64'h3);
		end_sim();
	end
endmodule
